// File: hw/pcs_core.sv
// Program counter sequencing unit: the counter, its paged loading and the
// return stack traffic of calls, interrupt vectoring and returns.
// Assumes one request class per instruction from the decoder, all synchronous
// to clock_i; simultaneous requests are resolved by a fixed priority.
// Only the low counter byte and the latch read back; the upper counter bits
// leave the block solely on the fetch address.
`timescale 1ns/1ps
`default_nettype none

module pcs_core #(
  parameter logic [pcs_pkg::PC_W-1:0] VECTOR_ADDR = 13'h0004  // Interrupt vector.
) (
  input  wire logic                         clock_i,
  input  wire logic                         rst_n_i,
  input  wire logic                         fetch_i,
  input  wire logic                         low_wr_i,
  input  wire logic [pcs_pkg::LOW_W-1:0]    low_wdata_i,
  input  wire logic                         latch_wr_i,
  input  wire logic [pcs_pkg::LOW_W-1:0]    latch_wdata_i,
  input  wire logic                         jump_i,
  input  wire logic                         call_i,
  input  wire logic [pcs_pkg::TGT_W-1:0]    target_i,
  input  wire logic                         vector_i,
  input  wire logic                         return_i,
  input  wire logic                         return_with_literal_i,
  input  wire logic                         return_from_interrupt_i,
  output logic      [pcs_pkg::PC_W-1:0]     pc_o,
  output logic      [pcs_pkg::LOW_W-1:0]    counter_low_byte_o,
  output logic      [pcs_pkg::LOW_W-1:0]    counter_high_holding_latch_o
);

  // ==========================================================================
  // Decoding helpers
  // ==========================================================================

  // Builds a paged branch address from the page bits and the target field.
  function automatic logic [pcs_pkg::PC_W-1:0] paged_addr(
    input logic [pcs_pkg::LATCH_W-1:0] latch,
    input logic [pcs_pkg::TGT_W-1:0]   target
  );
    paged_addr = {latch[pcs_pkg::PAGE_MSB:pcs_pkg::PAGE_LSB], target};
  endfunction

  // Picks one operation; returns first, then vectoring, calls, jumps, low
  // byte writes and plain steps, so a branch always beats a fetch.
  function automatic pcs_pkg::pcs_op_t pick_op(
    input logic ret,
    input logic vec,
    input logic call,
    input logic jump,
    input logic low,
    input logic step
  );
    if (ret) begin
      pick_op = pcs_pkg::PCS_OP_RET;
    end else if (vec) begin
      pick_op = pcs_pkg::PCS_OP_VEC;
    end else if (call) begin
      pick_op = pcs_pkg::PCS_OP_CALL;
    end else if (jump) begin
      pick_op = pcs_pkg::PCS_OP_JUMP;
    end else if (low) begin
      pick_op = pcs_pkg::PCS_OP_LOW;
    end else if (step) begin
      pick_op = pcs_pkg::PCS_OP_STEP;
    end else begin
      pick_op = pcs_pkg::PCS_OP_HOLD;
    end
  endfunction

  // ==========================================================================
  // Signals
  // ==========================================================================
  pcs_stack_if                        stk ();
  pcs_pkg::pcs_op_t                   op_sel;
  logic                               any_return;
  logic [pcs_pkg::PC_W-1:0]           pc_q;
  logic [pcs_pkg::PC_W-1:0]           pc_d;
  logic [pcs_pkg::PC_W-1:0]           pc_step;
  logic [pcs_pkg::PC_W-1:0]           pc_low;
  logic [pcs_pkg::PC_W-1:0]           pc_branch;
  logic [pcs_pkg::LATCH_W-1:0]        latch;

  // ==========================================================================
  // Holding latch and return stack
  // ==========================================================================

  // The latch is a plain software register; nothing else writes it.
  // Stack traffic never reaches its write strobe, so returns keep its value.
  pcs_latch u_latch (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .wr_i    (latch_wr_i),
    .wdata_i (latch_wdata_i),
    .latch_o (latch),
    .rdata_o (counter_high_holding_latch_o)
  );

  // The stack has no software port at all, only the store modport.
  pcs_stack #(
    .DEPTH (pcs_pkg::STACK_D)
  ) u_stack (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .stk     (stk.store)
  );

  // ==========================================================================
  // Operation select and candidate addresses
  // ==========================================================================

  // All three return kinds behave the same for the counter.
  assign any_return = return_i | return_with_literal_i | return_from_interrupt_i;
  assign op_sel     = pick_op(any_return, vector_i, call_i, jump_i, low_wr_i, fetch_i);

  // Candidate next values for each kind of load.
  assign pc_step   = pc_q + pcs_pkg::PC_ONE;
  assign pc_low    = {latch, low_wdata_i};
  assign pc_branch = paged_addr(latch, target_i);

  // Push and pop come from one decoded operation, so they never meet in one
  // cycle; the stack relies on that, and were they to meet its push would win.
  // Stack requests; a push carries the return address, the current counter.
  assign stk.push      = (op_sel == pcs_pkg::PCS_OP_CALL) |
                         (op_sel == pcs_pkg::PCS_OP_VEC);
  assign stk.pop       = (op_sel == pcs_pkg::PCS_OP_RET);
  assign stk.push_data = pc_q;

  // ==========================================================================
  // Next counter value
  // ==========================================================================

  // A pop on an empty stack is not flagged; it returns the wrapped slot.
  // Chooses the next counter from the selected operation.
  always_comb begin
    case (op_sel)
      pcs_pkg::PCS_OP_STEP: pc_d = pc_step;
      pcs_pkg::PCS_OP_LOW:  pc_d = pc_low;
      pcs_pkg::PCS_OP_JUMP: pc_d = pc_branch;
      pcs_pkg::PCS_OP_CALL: pc_d = pc_branch;
      pcs_pkg::PCS_OP_VEC:  pc_d = VECTOR_ADDR;
      pcs_pkg::PCS_OP_RET:  pc_d = stk.pop_data;
      pcs_pkg::PCS_OP_HOLD: pc_d = pc_q;
      default:              pc_d = pc_q;
    endcase
  end

  // Counter register; reset clears all thirteen bits.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pc_q <= pcs_pkg::PC_RST;
    end else begin
      pc_q <= pc_d;
    end
  end

  // Only the low byte is readable; upper bits leave only on the fetch bus.
  assign pc_o               = pc_q;
  assign counter_low_byte_o = pc_q[pcs_pkg::LOW_W-1:0];

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  // Named steps of a call followed directly by a return.
  sequence s_call;
    op_sel == pcs_pkg::PCS_OP_CALL;
  endsequence

  sequence s_return;
    op_sel == pcs_pkg::PCS_OP_RET;
  endsequence

  property p_reset_clears;
    @(posedge clock_i) disable iff (1'b0)
    !rst_n_i |=> pc_q[pcs_pkg::PC_W-1:pcs_pkg::LOW_W] == 5'h00;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("Upper bits not cleared.");

  property p_low_write;
    op_sel == pcs_pkg::PCS_OP_LOW |=> pc_q == {$past(latch), $past(low_wdata_i)};
  endproperty
  a_low_write: assert property (p_low_write) else $error("Low write did not load latch.");

  property p_paged_jump;
    op_sel == pcs_pkg::PCS_OP_JUMP |=>
      pc_q[12:11] == $past(latch[4:3]) && pc_q[10:0] == $past(target_i);
  endproperty
  a_paged_jump: assert property (p_paged_jump) else $error("Jump page or target wrong.");

  property p_step;
    op_sel == pcs_pkg::PCS_OP_STEP |=> pc_q == $past(pc_q) + pcs_pkg::PC_ONE;
  endproperty
  a_step: assert property (p_step) else $error("Counter did not step by one.");

  property p_call_return;
    s_call ##1 s_return |=> pc_q == $past(pc_q, 2);
  endproperty
  a_call_return: assert property (p_call_return) else $error("Return lost call address.");

  property p_vector;
    vector_i && !any_return |=> pc_q == VECTOR_ADDR ##1 1'b1;
  endproperty
  a_vector: assert property (p_vector) else $error("Vector not taken.");

  property p_latch_kept;
    (stk.push || stk.pop) && !latch_wr_i |=> latch == $past(latch);
  endproperty
  a_latch_kept: assert property (p_latch_kept) else $error("Stack traffic moved latch.");

  property p_upper_hidden;
    op_sel == pcs_pkg::PCS_OP_HOLD |=> $stable(pc_q) && counter_low_byte_o == pc_q[7:0];
  endproperty
  a_upper_hidden: assert property (p_upper_hidden) else $error("Counter moved on hold.");

  // ==========================================================================
  // Checks of stack traffic, paged loading, latch read-back and reset
  // ==========================================================================
  // Interrupt vectoring as a named step, for the vector and return pair.
  sequence s_vector;
    op_sel == pcs_pkg::PCS_OP_VEC;
  endsequence

  // A call loads the page bits of the latch and the target field.
  property p_call_page;
    s_call |=>
      pc_q[12:11] == $past(latch[4:3]) && pc_q[10:0] == $past(target_i);
  endproperty
  a_call_page: assert property (p_call_page)
    else $error("Call page or target wrong.");

  // Vectoring then a return restores the interrupted counter.
  property p_vector_return;
    s_vector ##1 s_return |=> pc_q == $past(pc_q, 2);
  endproperty
  a_vector_return: assert property (p_vector_return)
    else $error("Return lost vector address.");

  // A return pops once and never pushes, so the stack sees one request.
  property p_return_single;
    s_return |-> stk.pop && !stk.push;
  endproperty
  a_return_single: assert property (p_return_single)
    else $error("Return did not pop alone.");

  // The literal and interrupt returns pop exactly like the plain one.
  property p_return_kinds;
    (return_with_literal_i || return_from_interrupt_i) |->
      stk.pop && op_sel == pcs_pkg::PCS_OP_RET;
  endproperty
  a_return_kinds: assert property (p_return_kinds)
    else $error("Return kind did not pop.");

  // A call or vectoring request that no return outranks pushes the counter.
  property p_push_source;
    (call_i || vector_i) && !any_return |-> stk.push;
  endproperty
  a_push_source: assert property (p_push_source)
    else $error("Branch did not push.");

  // A low byte write touches neither the stack nor its pointer.
  property p_low_no_stack;
    op_sel == pcs_pkg::PCS_OP_LOW |-> !stk.push && !stk.pop;
  endproperty
  a_low_no_stack: assert property (p_low_no_stack)
    else $error("Low write moved the stack.");

  // A latch write shows its five kept bits on the read port next cycle.
  property p_latch_readback;
    latch_wr_i |=> counter_high_holding_latch_o == (8'h1F & $past(latch_wdata_i));
  endproperty
  a_latch_readback: assert property (p_latch_readback)
    else $error("Latch read-back wrong.");

  // Any reset clears the whole counter and the latch, not only upper bits.
  property p_reset_whole;
    @(posedge clock_i) disable iff (1'b0)
    !rst_n_i |=> pc_q == pcs_pkg::PC_RST && counter_high_holding_latch_o == 8'h00;
  endproperty
  a_reset_whole: assert property (p_reset_whole)
    else $error("Reset left state behind.");

endmodule

`default_nettype wire

// File: hw/pcs_pkg.sv
// Package for the program counter sequencing unit: widths, reset values,
// field positions and the one-hot encoding of the sequencing operation.
// Assumes nothing of its surroundings; every user names items as pcs_pkg::name.
`default_nettype none

package pcs_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int PC_W     = 13;  // Full program counter.
  localparam int LOW_W    = 8;   // Software-visible low byte.
  localparam int UP_W     = 5;   // Upper counter bits 12..8.
  localparam int TGT_W    = 11;  // Target field of a call or jump.
  localparam int PAGE_W   = 2;   // Page select width.
  localparam int LATCH_W  = 5;   // Implemented bits of the holding latch.
  localparam int STACK_D  = 8;   // Return stack depth.
  localparam int PTR_W    = 3;   // Stack pointer width.

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int PAGE_LSB = 3;   // Page select bits sit at latch bits 4..3.
  localparam int PAGE_MSB = 4;

  // ==========================================================================
  // Reset values and constants
  // ==========================================================================
  localparam logic [PC_W-1:0]    PC_RST    = 13'h0000;
  localparam logic [PC_W-1:0]    PC_ONE    = 13'h0001;
  localparam logic [LATCH_W-1:0] LATCH_RST = 5'h00;
  localparam logic [PTR_W-1:0]   PTR_RST   = 3'h0;
  localparam logic [PTR_W-1:0]   PTR_ONE   = 3'h1;
  localparam logic [2:0]         LATCH_PAD = 3'h0;  // Unbuilt latch bits read 0.

  // ==========================================================================
  // Sequencing operation, one-hot
  // ==========================================================================
  typedef enum logic [6:0] {
    PCS_OP_HOLD = 7'h01,
    PCS_OP_STEP = 7'h02,
    PCS_OP_LOW  = 7'h04,
    PCS_OP_JUMP = 7'h08,
    PCS_OP_CALL = 7'h10,
    PCS_OP_VEC  = 7'h20,
    PCS_OP_RET  = 7'h40
  } pcs_op_t;

endpackage

`default_nettype wire

// File: hw/pcs_stack_if.sv
// Interface between the counter core and its return stack.
// Assumes both ends share one clock; push and pop are one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none

interface pcs_stack_if;
  logic                      push;
  logic                      pop;
  logic [pcs_pkg::PC_W-1:0]  push_data;
  logic [pcs_pkg::PC_W-1:0]  pop_data;

  // The core requests operations and reads the top entry.
  modport core  (output push, output pop, output push_data, input pop_data);
  // The store keeps the entries and shows the top entry.
  modport store (input push, input pop, input push_data, output pop_data);
endinterface

`default_nettype wire

// File: hw/pcs_stack.sv
// Circular return stack of the counter sequencing unit.
// Assumes push and pop never arrive together; the core guarantees this.
`timescale 1ns/1ps
`default_nettype none

module pcs_stack #(
  parameter int DEPTH = pcs_pkg::STACK_D
) (
  input  wire logic          clock_i,
  input  wire logic          rst_n_i,
  pcs_stack_if.store         stk
);

  // ==========================================================================
  // Storage and pointer
  // ==========================================================================
  logic [pcs_pkg::PC_W-1:0]  mem_q [DEPTH];
  logic [pcs_pkg::PTR_W-1:0] ptr_q;
  logic [pcs_pkg::PTR_W-1:0] top_idx;

  // The top entry sits one below the write pointer; wrap is natural.
  assign top_idx      = ptr_q - pcs_pkg::PTR_ONE;
  assign stk.pop_data = mem_q[top_idx];

  // Pointer moves up on push and down on pop; it is hidden from software.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ptr_q <= pcs_pkg::PTR_RST;
    end else if (stk.push) begin
      ptr_q <= ptr_q + pcs_pkg::PTR_ONE;
    end else if (stk.pop) begin
      ptr_q <= top_idx;
    end
  end

  // A push overwrites the slot at the pointer, so a ninth push reuses slot 0.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= pcs_pkg::PC_RST;
      end
    end else if (stk.push) begin
      mem_q[ptr_q] <= stk.push_data;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_ptr_wraps;
    @(posedge clock_i) disable iff (!rst_n_i)
    stk.push [*8] |=> ptr_q == $past(ptr_q, 8);
  endproperty
  a_ptr_wraps: assert property (p_ptr_wraps) else $error("Stack pointer did not wrap.");

  property p_push_then_pop;
    @(posedge clock_i) disable iff (!rst_n_i)
    (stk.push && !stk.pop) ##1 (!stk.push) |-> stk.pop_data == $past(stk.push_data);
  endproperty
  a_push_then_pop: assert property (p_push_then_pop)
    else $error("Top entry is not last push.");

endmodule

`default_nettype wire

// File: hw/pcs_latch.sv
// Holding latch for the upper counter bits of the sequencing unit.
// Assumes the write strobe comes from the register write path only.
`timescale 1ns/1ps
`default_nettype none

module pcs_latch (
  input  wire logic                          clock_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          wr_i,
  input  wire logic [pcs_pkg::LOW_W-1:0]     wdata_i,
  output logic      [pcs_pkg::LATCH_W-1:0]   latch_o,
  output logic      [pcs_pkg::LOW_W-1:0]     rdata_o
);

  logic [pcs_pkg::LATCH_W-1:0] latch_q;

  // Only software writes change the latch; stack traffic never does.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      latch_q <= pcs_pkg::LATCH_RST;
    end else if (wr_i) begin
      latch_q <= wdata_i[pcs_pkg::LATCH_W-1:0];
    end
  end

  // Upper latch bits are not built and read as zero.
  assign latch_o = latch_q;
  assign rdata_o = {pcs_pkg::LATCH_PAD, latch_q};

endmodule

`default_nettype wire

// File: verification/pcs_prog_model.sv
// Behavioural model of the instruction decoder and the running program.
// Assumes one clock; every request line changes at the falling edge only.
`timescale 1ns/1ps
`default_nettype none

module pcs_prog_model (
  input  wire logic        clock_i,
  output logic             fetch_o,
  output logic             low_wr_o,
  output logic [7:0]       low_wdata_o,
  output logic             latch_wr_o,
  output logic [7:0]       latch_wdata_o,
  output logic             jump_o,
  output logic             call_o,
  output logic [10:0]      target_o,
  output logic             vector_o,
  output logic             return_o,
  output logic             return_with_literal_o,
  output logic             return_from_interrupt_o
);
  // ==========================================================================
  // Request driver
  // ==========================================================================
  // Codes: 0 hold, 1 step, 2 low write, 3 latch write, 4 jump, 5 call,
  // 6 vector, 7 return, 8 return with literal, 9 return from interrupt,
  // 10 low and latch write together, 11 call and return together.
  // Data not qualified by its strobe shows the inverse, so stale values never
  // pass for fresh ones.
  task automatic issue(input int c, input logic [10:0] a);
    @(negedge clock_i);
    fetch_o                 = (c == 1);
    low_wr_o                = (c == 2 || c == 10);  // Tables stay inside one 256-word block.
    low_wdata_o             = (c == 2 || c == 10) ? a[7:0] : ~a[7:0];
    latch_wr_o              = (c == 3 || c == 10);  // Page bits are set before a branch.
    latch_wdata_o           = (c == 3 || c == 10) ? a[7:0] : ~a[7:0];
    jump_o                  = (c == 4);
    call_o                  = (c == 5 || c == 11);
    target_o                = (c == 4 || c == 5 || c == 11) ? a : ~a;
    vector_o                = (c == 6);
    return_o                = (c == 7 || c == 11);
    return_with_literal_o   = (c == 8);
    return_from_interrupt_o = (c == 9);
  endtask

  // All lines idle from the first falling edge.
  initial begin
    issue(0, 11'h000);
  end
endmodule

`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench of the counter sequencing unit.
// Assumes the program model drives every request; the bench drives reset.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam logic [12:0] VEC_ADDR = 13'h0A04;

  logic        clock_i;
  logic        rst_n_i;
  logic        fetch, low_wr, latch_wr, jump, call, vector;
  logic        ret, ret_lit, ret_int;
  logic [7:0]  low_wdata, latch_wdata, low_byte, latch_rd;
  logic [10:0] target;
  logic [12:0] pc_o;
  int          pc, latch, ptr, n_errors, total_checks;
  int          stk [8];

  // ==========================================================================
  // Clock, program model and design
  // ==========================================================================
  // A 40 ns clock period.
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  pcs_prog_model prog (.clock_i(clock_i), .fetch_o(fetch), .low_wr_o(low_wr),
    .low_wdata_o(low_wdata), .latch_wr_o(latch_wr), .latch_wdata_o(latch_wdata),
    .jump_o(jump), .call_o(call), .target_o(target), .vector_o(vector),
    .return_o(ret), .return_with_literal_o(ret_lit), .return_from_interrupt_o(ret_int));

  pcs_core #(.VECTOR_ADDR(VEC_ADDR)) dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .fetch_i(fetch), .low_wr_i(low_wr), .low_wdata_i(low_wdata), .latch_wr_i(latch_wr),
    .latch_wdata_i(latch_wdata), .jump_i(jump), .call_i(call), .target_i(target),
    .vector_i(vector), .return_i(ret), .return_with_literal_i(ret_lit),
    .return_from_interrupt_i(ret_int), .pc_o(pc_o), .counter_low_byte_o(low_byte),
    .counter_high_holding_latch_o(latch_rd));

  // ==========================================================================
  // Reference model and checks
  // ==========================================================================
  // Compares counter, low byte and latch read-back with the model.
  task automatic check_all();
    total_checks++;
    if (pc_o !== pc[12:0] || low_byte !== pc[7:0]) begin
      n_errors++;
      $display("BAD %0t pc %h low %h expected %h", $time, pc_o, low_byte, pc[12:0]);
    end
    total_checks++;
    if (latch_rd !== {3'h0, latch[4:0]}) begin
      n_errors++;
      $display("BAD %0t latch %h expected %h", $time, latch_rd, latch[4:0]);
    end
  endtask

  // Issues one request, updates the model at the taking edge, then compares.
  task automatic op(input int c, input logic [10:0] a);
    prog.issue(c, a);
    @(posedge clock_i);
    case (c)
      1: pc = (pc + 1) % 8192;
      2: pc = latch * 256 + a[7:0];
      3: latch = a[4:0];
      10: begin
        pc = latch * 256 + a[7:0];
        latch = a[4:0];
      end
      4: pc = (latch / 8) * 2048 + a;
      5, 6: begin
        stk[ptr] = pc;
        ptr = (ptr + 1) % 8;
        pc = (c == 5) ? (latch / 8) * 2048 + a : VEC_ADDR;
      end
      7, 8, 9, 11: begin
        ptr = (ptr + 7) % 8;
        pc = stk[ptr];
      end
      default: ;
    endcase
    #1;
    check_all();
  endtask

  // Holds reset for n cycles with the program idle, then clears the model.
  task automatic do_reset(input int n);
    prog.issue(0, 11'h000);
    rst_n_i = 1'b0;
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
    rst_n_i = 1'b1;
    pc = 0;
    latch = 0;
    ptr = 0;
    foreach (stk[i]) stk[i] = 0;
    #1;
    check_all();
  endtask

  // Prints the verdict and ends the run.
  task automatic close_out();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #800000;
    n_errors++;
    close_out();
  end

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Main sequence.
  initial begin
    rst_n_i = 1'b0;
    n_errors = 0;
    total_checks = 0;
    void'($urandom(32'hB41C));
    do_reset(8);
    // Paged calls, then each return kind with the latch rewritten in between.
    for (int k = 7; k <= 9; k++) begin
      op(3, 11'h018 | k[10:0]);
      op(5, 11'h5A5 + k[10:0]);
      op(3, 11'h008);
      op(k, 11'h000);
      op(1, 11'h000);
    end
    // Ten calls wrap the eight entries; ten returns then unwind them.
    op(3, 11'h010);
    for (int i = 0; i < 10; i++) op(5, 11'h100 + i[10:0]);
    for (int i = 0; i < 10; i++) op(7, 11'h000);
    // Low write at the top of the space, then the step wraps to zero.
    op(3, 11'h01F);
    op(2, 11'h0FF);
    op(1, 11'h000);
    op(4, 11'h7FF);
    op(6, 11'h000);
    op(9, 11'h000);
    // A call returned at once, then requests that meet in one cycle.
    op(5, 11'h2C3);
    op(8, 11'h000);
    op(10, 11'h0E7);
    op(11, 11'h123);
    // Random back-to-back requests of every kind.
    repeat (400) op($urandom_range(11, 0), 11'($urandom));
    // Reset in mid-run clears the counter.
    op(3, 11'h01F);
    op(2, 11'h080);
    do_reset(1);
    op(1, 11'h000);
    close_out();
  end
endmodule

`default_nettype wire
